// *** hw/cpr_dev.sv ***
// Purpose: Coprocessor end of the register port with the context-restore dialog
// Assumes: Core logic beside it supplies responses, save format and completion
// Notes: Reads return data one cycle after the strobe; unmapped reads return zero
// What this block does
// - Host skips empty frame, else sends byte count
// - Restore write stops work, evaluates format
// - Valid format echoed, then bytes accepted
// - Host reads restore register back after writing
// - Host moves frame bytes into operand register
// - Invalid format: invalid code returned, work stopped
// - Invalid code: host writes abort, format error
// - No supervisor: privilege fault, no access
// - Service requests in 16-bit register, offset zero
// - Control at offset two, two bits only
// - Take-exception acknowledged by writing bit one
// - Abort by writing control bit zero
// - Host aborts on format faults and on abort_go; privilege fault makes no access
// - Save register offset four; read starts save
// - Response through operand registers, offsets 08 and 0C not implemented
// - Abort mask is 0001 then format error
// - Restore register offset six, format both ways
// - Operand at sixteen, long words, MSB aligned
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
module cpr_dev
  import cpr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  cpr_if.dev bus,
  input wire logic [15:0] resp_word,
  input wire logic [15:0] save_word,
  input wire logic core_done,
  output logic [15:0] cmd_word,
  output logic cmd_stb,
  output logic [5:0] cond_sel,
  output logic cond_stb,
  output logic [31:0] opnd_data,
  output logic opnd_stb,
  output logic abort_stb,
  output logic xack_stb,
  output logic save_stb,
  output logic restore_done,
  output logic busy
);
  typedef enum logic [1:0] {CPR_D_IDLE, CPR_D_RX, CPR_D_BUSY} cpr_dstate_t;

  // Registers and decodes
  cpr_dstate_t state_q; // Dialog state
  logic [15:0] rest_q; // Restore register contents
  logic [7:0] cnt_q; // Frame bytes still expected
  logic [31:0] rdata_q; // Read data register
  cpr_fkind_t kind; // Classification of the write data
  logic wr_rest, wr_ctrl, wr_cmd, wr_cond, wr_opnd; // Write decodes
  logic rd_save; // Save register read
  logic ctrl_abort; // Abort bit written
  logic last_word; // Final operand write of an accepted frame

  // Write decode; the restore dialog and abort both act on the strobe cycle
  assign wr_rest = bus.wr && bus.addr == CPR_OFS_REST;
  assign wr_ctrl = bus.wr && bus.addr == CPR_OFS_CTRL;
  assign wr_cmd = bus.wr && bus.addr == CPR_OFS_CMD;
  assign wr_cond = bus.wr && bus.addr == CPR_OFS_COND;
  assign wr_opnd = bus.wr && bus.addr == CPR_OFS_OPND;
  assign rd_save = bus.rd && bus.addr == CPR_OFS_SAVE;
  // Only bit 0 is looked at for abort; bit 1 is the acknowledge
  assign ctrl_abort = wr_ctrl && bus.wdata[CPR_CTRL_CANCEL];
  // Last operand write of a frame; a short tail still counts as one word
  assign last_word = state_q == CPR_D_RX && wr_opnd && cnt_q <= CPR_LWORD_BYTES;

  // Judges the write data every cycle; the verdict only matters on a restore write
  // Kept combinational so the decision lands on the same edge as the write
  cpr_fmt_chk cpr_fmt_chk_inst (
    .fmt(bus.wdata[15:0]),
    .kind(kind)
  );

  // Dialog state machine
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= CPR_D_IDLE;
    end else if (wr_rest) begin
      // Any work in progress is dropped before the new frame is judged
      if (kind == CPR_FK_VALID) begin
        state_q <= CPR_D_RX;
      end else begin
        state_q <= CPR_D_IDLE;
      end
    end else if (ctrl_abort) begin
      state_q <= CPR_D_IDLE;
    end else begin
      unique case (state_q)
        CPR_D_IDLE: begin
          if (wr_cmd || wr_cond) begin
            state_q <= CPR_D_BUSY;
          end
        end
        CPR_D_RX: begin
          // Last transfer may carry fewer than four bytes
          if (last_word) begin
            state_q <= CPR_D_IDLE;
          end
        end
        CPR_D_BUSY: begin
          if (core_done) begin
            state_q <= CPR_D_IDLE;
          end
        end
        // Unused code; recover to idle rather than hang
        default: begin
          state_q <= CPR_D_IDLE;
        end
      endcase
    end
  end

  // Restore register: echo of a valid or empty frame, or the invalid code
  always_ff @(posedge clk) begin
    if (srst) begin
      rest_q <= CPR_REST_RESET;
    end else if (wr_rest) begin
      if (kind == CPR_FK_INVALID) begin
        rest_q <= CPR_FMT_INVALID;
      end else begin
        rest_q <= bus.wdata[15:0];
      end
    end
  end

  // Bytes still expected for the frame being restored
  // Saturates at zero, so a short tail never wraps the count
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= 8'h00;
    end else if (wr_rest) begin
      cnt_q <= (kind == CPR_FK_VALID) ? bus.wdata[CPR_FMT_LEN_LSB +: 8] : 8'h00;
    end else if (state_q == CPR_D_RX && wr_opnd) begin
      cnt_q <= (cnt_q > CPR_LWORD_BYTES) ? cnt_q - CPR_LWORD_BYTES : 8'h00;
    end
  end

  // Read data, valid only in the cycle after the strobe
  // Zero outside the answer cycle keeps stale data off the port
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus.rd) begin
      unique case (bus.addr)
        CPR_OFS_RESP: rdata_q <= {16'h0000, resp_word};
        CPR_OFS_SAVE: rdata_q <= {16'h0000, save_word};
        CPR_OFS_REST: rdata_q <= {16'h0000, rest_q};
        // Control is write-only; reserved bits and the rest read zero
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign bus.rdata = rdata_q;

  // Captured words passed to the core
  // Held until overwritten; the core picks them up after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_word <= 16'h0000;
      cond_sel <= CPR_COND_RESET;
      opnd_data <= 32'h0000_0000;
    end else begin
      if (wr_cmd) begin
        cmd_word <= bus.wdata[15:0];
      end
      if (wr_cond) begin
        cond_sel <= bus.wdata[5:0];
      end
      if (wr_opnd) begin
        opnd_data <= bus.wdata;
      end
    end
  end

  // One-cycle strobes to the core, a cycle after the bus access
  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_stb <= 1'b0;
      cond_stb <= 1'b0;
      opnd_stb <= 1'b0;
      abort_stb <= 1'b0;
      xack_stb <= 1'b0;
      save_stb <= 1'b0;
      restore_done <= 1'b0;
    end else begin
      cmd_stb <= wr_cmd;
      cond_stb <= wr_cond;
      opnd_stb <= wr_opnd;
      // A restore write also terminates whatever the core is doing
      abort_stb <= ctrl_abort || wr_rest;
      xack_stb <= wr_ctrl && bus.wdata[CPR_CTRL_XACK];
      save_stb <= rd_save;
      // A cancel in the same cycle wins over completion
      restore_done <= last_word && !wr_rest && !ctrl_abort;
    end
  end

  // Busy spans frame reception and core work; abort or a restore of a non-valid frame clears it
  assign busy = state_q != CPR_D_IDLE;
endmodule

// *** common/cpr_pkg.sv ***
// Purpose: Shared constants and types for the coprocessor context-restore register port
// Assumes: Offsets are byte addresses within the register set, as printed
// Notes: Format word layout is [15:8] format code, [7:0] frame length in bytes
package cpr_pkg;
  // Register offsets
  localparam logic [4:0] CPR_OFS_RESP = 5'h00; // Service request word
  localparam logic [4:0] CPR_OFS_CTRL = 5'h02; // Abort and acknowledge control
  localparam logic [4:0] CPR_OFS_SAVE = 5'h04; // Context save format
  localparam logic [4:0] CPR_OFS_REST = 5'h06; // Context restore format
  localparam logic [4:0] CPR_OFS_CMD = 5'h0A; // Command word
  localparam logic [4:0] CPR_OFS_COND = 5'h0E; // Condition selector
  localparam logic [4:0] CPR_OFS_OPND = 5'h10; // Operand register
  // Control register fields
  localparam int CPR_CTRL_CANCEL = 0; // cancel_flag position
  localparam int CPR_CTRL_XACK = 1; // exception_ack_bit position
  localparam logic [15:0] CPR_MASK_ABORT = 16'h0001; // Abort mask
  localparam logic [15:0] CPR_MASK_XACK = 16'h0002; // Acknowledge mask
  // Format word fields
  localparam int CPR_FMT_CODE_LSB = 8;
  localparam int CPR_FMT_LEN_LSB = 0;
  localparam logic [7:0] CPR_CODE_INVALID = 8'h01; // Invalid-format code
  localparam logic [7:0] CPR_CODE_ACCEPT = 8'h40; // Format accepted by this design
  localparam logic [7:0] CPR_CTX_LEN = 8'h0A; // Frame length accepted by this design
  localparam logic [15:0] CPR_FMT_INVALID = 16'h0100; // Returned for a bad frame
  localparam logic [15:0] CPR_REST_RESET = 16'h0000; // Restore reg after reset
  localparam logic [7:0] CPR_LWORD_BYTES = 8'h04; // Bytes per operand transfer
  localparam logic [5:0] CPR_COND_RESET = 6'h00;
  // Result of format evaluation
  typedef enum logic [1:0] {CPR_FK_EMPTY, CPR_FK_VALID, CPR_FK_INVALID} cpr_fkind_t;
endpackage

// *** common/cpr_if.sv ***
// Purpose: Register port joining the main processor end and the coprocessor end
// Assumes: Single clock; read data stand in the cycle after the read strobe only
// Notes: Strobes are one cycle long and never both high at once
`timescale 1ns/10ps
interface cpr_if (
  input wire logic clk
);
  logic [4:0] addr; // Byte offset in the register set
  logic [31:0] wdata; // Write data, 16-bit registers use the low half
  logic wr; // Write strobe
  logic rd; // Read strobe
  logic [31:0] rdata; // Read data, one cycle after rd
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// *** hw/cpr_fmt_chk.sv ***
// Purpose: Classifies a written restore format word
// Assumes: Purely combinational, used by the coprocessor end
// Notes: Only one code and one length are accepted as a valid context
`timescale 1ns/10ps
module cpr_fmt_chk
  import cpr_pkg::*;
(
  input wire logic [15:0] fmt,
  output cpr_fkind_t kind
);
  logic [7:0] code; // Format code field
  logic [7:0] len; // Length field
  assign code = fmt[CPR_FMT_CODE_LSB +: 8];
  assign len = fmt[CPR_FMT_LEN_LSB +: 8];

  // Empty or reset frame carries no bytes; any other unknown code or length is rejected
  always_comb begin
    if (len == 8'h00 && code != CPR_CODE_INVALID) begin
      kind = CPR_FK_EMPTY;
    end else if (code == CPR_CODE_ACCEPT && len == CPR_CTX_LEN) begin
      kind = CPR_FK_VALID;
    end else begin
      kind = CPR_FK_INVALID;
    end
  end
endmodule

// *** hw/cpr_host.sv ***
// Purpose: Main processor end driving the register port
// Assumes: Frame memory beside it answers frame_idx combinationally
// Notes: One operation at a time; go strobes while busy are ignored
`timescale 1ns/10ps
module cpr_host
  import cpr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  cpr_if.host bus,
  input wire logic rest_go,
  input wire logic [15:0] fmt_in,
  input wire logic super_bit,
  input wire logic [31:0] frame_data,
  input wire logic abort_go,
  input wire logic ack_go,
  input wire logic save_go,
  input wire logic resp_go,
  output logic [7:0] frame_idx,
  output logic [15:0] rd_word,
  output logic done,
  output logic priv_err,
  output logic fmt_err,
  output logic busy
);
  typedef enum logic [2:0] {CPR_H_IDLE, CPR_H_WFMT, CPR_H_RFMT, CPR_H_CWAIT, CPR_H_CHECK, CPR_H_XFER,
                            CPR_H_SWAIT, CPR_H_RWAIT} cpr_hstate_t;

  cpr_hstate_t state_q; // Sequencer state
  logic [7:0] cnt_q; // Frame bytes left to move
  logic [15:0] fmt_q; // Format word being restored
  logic [15:0] echo; // Restore register as read back

  assign echo = bus.rdata[15:0];

  // Sequencer; a restore without supervisor right never touches the port
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= CPR_H_IDLE;
      cnt_q <= 8'h00;
      fmt_q <= 16'h0000;
      frame_idx <= 8'h00;
      bus.addr <= 5'h00;
      bus.wdata <= 32'h0000_0000;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      rd_word <= 16'h0000;
      done <= 1'b0;
      priv_err <= 1'b0;
      fmt_err <= 1'b0;
    end else begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      done <= 1'b0;
      priv_err <= 1'b0;
      fmt_err <= 1'b0;
      unique case (state_q)
        CPR_H_IDLE: begin
          if (rest_go) begin
            if (!super_bit) begin
              priv_err <= 1'b1;
            end else begin
              fmt_q <= fmt_in;
              state_q <= CPR_H_WFMT;
            end
          end else if (abort_go || ack_go) begin
            // Abort wins when both are asked for
            bus.addr <= CPR_OFS_CTRL;
            bus.wdata <= {16'h0000, abort_go ? CPR_MASK_ABORT : CPR_MASK_XACK};
            bus.wr <= 1'b1;
            done <= 1'b1;
          end else if (save_go || resp_go) begin
            bus.addr <= save_go ? CPR_OFS_SAVE : CPR_OFS_RESP;
            bus.rd <= 1'b1;
            state_q <= CPR_H_SWAIT;
          end
        end
        CPR_H_WFMT: begin
          bus.addr <= CPR_OFS_REST;
          bus.wdata <= {16'h0000, fmt_q};
          bus.wr <= 1'b1;
          state_q <= CPR_H_RFMT;
        end
        CPR_H_RFMT: begin
          bus.addr <= CPR_OFS_REST;
          bus.rd <= 1'b1;
          state_q <= CPR_H_CWAIT;
        end
        CPR_H_CWAIT: begin
          // Answer stands in the next cycle, not this one
          state_q <= CPR_H_CHECK;
        end
        CPR_H_CHECK: begin
          // Read data stand in this cycle only
          rd_word <= echo;
          if (echo[CPR_FMT_CODE_LSB +: 8] == CPR_CODE_INVALID) begin
            bus.addr <= CPR_OFS_CTRL;
            bus.wdata <= {16'h0000, CPR_MASK_ABORT};
            bus.wr <= 1'b1;
            fmt_err <= 1'b1;
            state_q <= CPR_H_IDLE;
          end else if (echo[CPR_FMT_LEN_LSB +: 8] == 8'h00) begin
            done <= 1'b1;
            state_q <= CPR_H_IDLE;
          end else begin
            cnt_q <= echo[CPR_FMT_LEN_LSB +: 8];
            frame_idx <= 8'h00;
            state_q <= CPR_H_XFER;
          end
        end
        CPR_H_XFER: begin
          // Long-word moves; memory supplies the tail already MSB aligned
          bus.addr <= CPR_OFS_OPND;
          bus.wdata <= frame_data;
          bus.wr <= 1'b1;
          frame_idx <= frame_idx + 8'h01;
          if (cnt_q <= CPR_LWORD_BYTES) begin
            cnt_q <= 8'h00;
            done <= 1'b1;
            state_q <= CPR_H_IDLE;
          end else begin
            cnt_q <= cnt_q - CPR_LWORD_BYTES;
          end
        end
        CPR_H_SWAIT: begin
          // Device samples the strobe now and answers next cycle
          state_q <= CPR_H_RWAIT;
        end
        CPR_H_RWAIT: begin
          rd_word <= bus.rdata[15:0];
          done <= 1'b1;
          state_q <= CPR_H_IDLE;
        end
      endcase
    end
  end

  assign busy = state_q != CPR_H_IDLE;
endmodule

// *** sim/cpr_asserts.sv ***
// Purpose: Protocol checks on the register port between both ends
// Assumes: One clock, srst synchronous and active high
// Notes: Sees only the interface wires, so core-side strobes are judged by the bench
`timescale 1ns/10ps
module cpr_asserts
  import cpr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [4:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata
);
  localparam logic [15:0] VALID_FMT = {CPR_CODE_ACCEPT, CPR_CTX_LEN}; // Only accepted frame
  logic rb_q; // High in the cycle the restore readback data stand

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Marks the readback cycle; cleared in reset so nothing stale fires after it
  always_ff @(posedge clk) begin
    rb_q <= !srst && rd && (addr == CPR_OFS_REST);
  end

  one_strobe_a: assert property (!(wr && rd))
    else $error("write and read strobe together");
  idle_rdata_a: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside the answer cycle");
  ctrl_reads_zero_a: assert property (rd && addr == CPR_OFS_CTRL |=> rdata == 32'h0)
    else $error("control read not zero");
  readback_a: assert property (wr && addr == CPR_OFS_REST |=> rd && addr == CPR_OFS_REST)
    else $error("restore write not read back");
  valid_echo_a: assert property (wr && addr == CPR_OFS_REST && wdata[15:0] == VALID_FMT
    |=> ##1 rdata[15:0] == VALID_FMT) else $error("valid format not echoed");
  invalid_code_a: assert property (wr && addr == CPR_OFS_REST && wdata[15:0] != VALID_FMT
    && (wdata[7:0] != 8'h00 || wdata[15:8] == CPR_CODE_INVALID) |=> ##1 rdata[15:0] == CPR_FMT_INVALID)
    else $error("invalid format not flagged");
  abort_mask_a: assert property (rb_q && rdata[15:0] == CPR_FMT_INVALID
    |=> wr && addr == CPR_OFS_CTRL && wdata[15:0] == CPR_MASK_ABORT) else $error("abort mask missing");
  // Ten bytes in long words: one cycle to decide, three writes, then the bus goes quiet
  frame_words_a: assert property (rb_q && rdata[15:0] == VALID_FMT
    |=> ##1 (wr && addr == CPR_OFS_OPND)[*3] ##1 !wr) else $error("wrong frame word count");
  empty_skip_a: assert property (rb_q && rdata[7:0] == 8'h00 && rdata[15:8] != CPR_CODE_INVALID
    |=> !wr [*2]) else $error("empty frame transferred");

  cover property (rb_q && rdata[15:0] == VALID_FMT);
  cover property (rb_q && rdata[15:0] == CPR_FMT_INVALID);
  cover property (wr && addr == CPR_OFS_CTRL && wdata[1]);
endmodule

// *** sim/tb_coproc_context_restore_regs.sv ***
// Purpose: Self-checking bench joining the host and coprocessor ends
// Assumes: Frame memory is a bench array answered combinationally
// Notes: core_done stays low; commands are not reachable from the host end
`timescale 1ns/10ps
module tb_coproc_context_restore_regs;
  import cpr_pkg::*;
  logic clk, srst, rest_go, super_bit, abort_go, ack_go, save_go, resp_go, core_done;
  logic [15:0] fmt_in, resp_word, save_word, rd_word, f;
  logic [31:0] frame_data, opnd_data;
  logic [7:0] frame_idx;
  logic done, priv_err, fmt_err, abort_stb, xack_stb, save_stb, restore_done, opnd_stb, d_busy, h_busy;
  logic [31:0] mem [0:255]; // Frame memory
  logic [31:0] opq [$]; // Operand words seen by the core
  int errors, num_checks, cyc, res, n_abort, n_xack, n_save, n_rdone, n_acc, n_busy, k;

  cpr_if bus_if (.clk(clk));
  cpr_host cpr_host_inst (.clk(clk), .srst(srst), .bus(bus_if.host), .rest_go(rest_go), .fmt_in(fmt_in),
    .super_bit(super_bit), .frame_data(frame_data), .abort_go(abort_go), .ack_go(ack_go), .save_go(save_go),
    .resp_go(resp_go), .frame_idx(frame_idx), .rd_word(rd_word), .done(done), .priv_err(priv_err),
    .fmt_err(fmt_err), .busy(h_busy));
  cpr_dev cpr_dev_inst (.clk(clk), .srst(srst), .bus(bus_if.dev), .resp_word(resp_word),
    .save_word(save_word), .core_done(core_done), .cmd_word(), .cmd_stb(), .cond_sel(), .cond_stb(),
    .opnd_data(opnd_data), .opnd_stb(opnd_stb), .abort_stb(abort_stb), .xack_stb(xack_stb),
    .save_stb(save_stb), .restore_done(restore_done), .busy(d_busy));
  cpr_asserts cpr_asserts_inst (.clk(clk), .srst(srst), .addr(bus_if.addr), .wdata(bus_if.wdata),
    .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata));

  assign frame_data = mem[frame_idx];

  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Verdict; the only place the run ends
  task wrap_up();
    if (errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Model side: tally what both ends show; also cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (done === 1'b1) res = 1;
    if (fmt_err === 1'b1) res = 2;
    if (priv_err === 1'b1) res = 3;
    if (opnd_stb === 1'b1) opq.push_back(opnd_data);
    n_abort += int'(abort_stb);
    n_xack += int'(xack_stb);
    n_save += int'(save_stb);
    n_rdone += int'(restore_done);
    n_acc += int'(bus_if.wr | bus_if.rd);
    n_busy += int'(d_busy);
    if (cyc == 3000) begin
      errors++;
      wrap_up();
    end
  end

  // One host operation: 0 restore, 1 abort, 2 acknowledge, 3 save, 4 response
  task automatic op(input int kind, input logic [15:0] fw);
    int w;
    res = 0;
    opq.delete();
    {n_abort, n_xack, n_save, n_rdone, n_acc, n_busy} = '0;
    rest_go <= (kind == 0);
    abort_go <= (kind == 1);
    ack_go <= (kind == 2);
    save_go <= (kind == 3);
    resp_go <= (kind == 4);
    fmt_in <= fw;
    @(posedge clk);
    {rest_go, abort_go, ack_go, save_go, resp_go} <= 5'h00;
    for (w = 0; w < 40 && res == 0; w++) begin
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask

  initial begin
    {rest_go, abort_go, ack_go, save_go, resp_go, core_done} = '0;
    super_bit = 1'b1;
    srst = 1'b1;
    fmt_in = 16'h0000;
    resp_word = 16'h0000;
    save_word = 16'h0000;
    void'($urandom(51653));
    for (k = 0; k < 256; k++) mem[k] = $urandom;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // Valid frame: echo, then ceil(len/4) words in order
    op(0, {CPR_CODE_ACCEPT, CPR_CTX_LEN});
    chk("result", res, 1);
    chk("echo", rd_word, {CPR_CODE_ACCEPT, CPR_CTX_LEN});
    chk("words", opq.size(), (CPR_CTX_LEN + 3) / 4);
    for (k = 0; k < opq.size(); k++) chk("operand", opq[k], mem[k]);
    chk("restore done", n_rdone, 1);
    chk("stop on restore", n_abort, 1);
    chk("dev busy", n_busy > 0, 1);
    // Bad formats: off-by-one length, invalid code, random words
    for (k = 0; k < 4; k++) begin
      f = 16'($urandom);
      if (f[7:0] == 8'h00) f[0] = 1'b1;
      if (f == {CPR_CODE_ACCEPT, CPR_CTX_LEN}) f[8] = ~f[8];
      if (k == 0) f = {CPR_CODE_ACCEPT, CPR_CTX_LEN - 8'h01};
      if (k == 1) f = CPR_FMT_INVALID;
      op(0, f);
      chk("result", res, 2);
      chk("invalid word", rd_word, CPR_FMT_INVALID);
      chk("aborts", n_abort, 2);
      chk("words", opq.size(), 0);
      chk("dev idle", d_busy, 0);
      chk("host idle", h_busy, 0);
    end
    // Empty frame is skipped
    op(0, {CPR_CODE_ACCEPT, 8'h00});
    chk("result", res, 1);
    chk("words", opq.size(), 0);
    // User level: no bus access at all
    super_bit <= 1'b0;
    op(0, {CPR_CODE_ACCEPT, CPR_CTX_LEN});
    chk("result", res, 3);
    chk("accesses", n_acc, 0);
    super_bit <= 1'b1;
    op(1, 16'h0000);
    chk("abort", n_abort, 1);
    chk("ack", n_xack, 0);
    op(2, 16'h0000);
    chk("ack", n_xack, 1);
    chk("abort", n_abort, 0);
    save_word <= 16'($urandom);
    resp_word <= 16'($urandom);
    op(3, 16'h0000);
    chk("save word", rd_word, save_word);
    chk("save start", n_save, 1);
    op(4, 16'h0000);
    chk("response", rd_word, resp_word);
    chk("save start", n_save, 0);
    wrap_up();
  end
endmodule
